// ===== pkg/oled_drive_pkg.sv
`default_nettype none
package oled_drive_pkg;
	// Command codes carried in bits 15:8 of a command word
	localparam logic [7:0] CMD_DIMMER = 8'h16;
	localparam logic [7:0] CMD_ROW_SELECT = 8'h17;
	localparam logic [7:0] CMD_COL_OVERRIDE = 8'h1A;
	localparam logic [7:0] CMD_PHASE1 = 8'h1B;
	// Avalon byte offsets
	localparam logic [3:0] ADDR_CMD = 4'h0;
	localparam logic [3:0] ADDR_DISPLAY = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	// Reset values
	localparam logic [4:0] DIMMER_RST = 5'h0F;
	localparam logic [1:0] ROW_MODE_RST = 2'h2;
	localparam logic ROW_DIR_RST = 1'h0;
	localparam logic [3:0] OVERRIDE_RST = 4'h0;
	localparam logic [5:0] PHASE1_COUNT_RST = 6'h0F;
	localparam logic [1:0] PHASE1_LEVEL_RST = 2'h0;
	// Field positions
	localparam int ROW_DIR_BIT = 4;
	localparam int POST_PWM_FLOAT_BIT = 0;
	localparam int HSYNC_FLOAT_BIT = 1;
	localparam int ALL_FLOAT_BIT = 2;
	localparam int ALL_SUPPLY_BIT = 3;
	localparam int PHASE1_LEVEL_LSB = 6;
	localparam int STATUS_PENDING_BIT = 5;
	localparam int STATUS_ROW_LSB = 8;
	localparam int STATUS_PHASE_LSB = 16;
	// Row modes and line counts
	localparam logic [1:0] ROW_MODE_SINGLE = 2'h2;
	localparam logic [1:0] ROW_MODE_DUAL = 2'h3;
	localparam logic [6:0] LINES_SINGLE = 7'h48;
	localparam logic [6:0] LINES_DUAL = 7'h24;
	// Default timing: scan divider in clocks, drive and hsync periods in scan clocks
	localparam int SCAN_DIV_DEFAULT = 8;
	localparam int DRIVE_CLKS_DEFAULT = 32;
	localparam int HSYNC_CLKS_DEFAULT = 2;
	typedef enum logic [1:0] {
		LVL_GROUND = 2'h0,
		LVL_FLOAT = 2'h1,
		LVL_SUPPLY = 2'h2,
		LVL_CURRENT = 2'h3
	} col_level_t;
	typedef enum logic [1:0] {
		PH_SETUP1 = 2'h0,
		PH_DRIVE = 2'h1,
		PH_HSYNC = 2'h3
	} phase_t;
endpackage
`default_nettype wire

// ===== hw/oled_drive_output_control.sv
// Overview of operation
// - Dimmer code sets column current (code+1)/16
// - Display on: new dimmer waits for vertical sync
// - Display off: new dimmer applies at once
// - Mode 10b scans 72 lines, 11b dual 36
// - Direction bit reverses row scan order
// - After PWM, column grounds or floats
// - Hsync output grounds or floats during pulse
// - All-float override floats columns outside hsync (ground during hsync), scan continues
// - All-supply override ties columns; float wins
// - Setup period 1 lasts code+1 scan clocks
// - Setup period 1 level field selects column drive
// - Level field only without all-float or all-supply override
// - Zero gray column grounds in setup period 1
`timescale 1ns/1ps
`default_nettype none
module oled_drive_output_control #(
	parameter int COLS = 256,
	parameter int SCAN_DIV = oled_drive_pkg::SCAN_DIV_DEFAULT,
	parameter int DRIVE_CLKS = oled_drive_pkg::DRIVE_CLKS_DEFAULT,
	parameter int HSYNC_CLKS = oled_drive_pkg::HSYNC_CLKS_DEFAULT
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	// Avalon-MM slave
	input wire logic [3:0] ADDRESS_I,
	input wire logic READ_I,
	input wire logic WRITE_I,
	input wire logic [31:0] WRITEDATA_I,
	output logic [31:0] READDATA_O,
	output logic WAITREQUEST_O,
	// Display side
	input wire logic VSYNC_I,
	input wire logic [COLS-1:0] GRAY_ZERO_I,
	input wire logic [COLS-1:0] PWM_ACTIVE_I,
	output logic [4:0] CURRENT_FRACTION_CODE_O,
	output logic [6:0] ROW_O,
	output logic DUAL_SCAN_O,
	output logic [2*COLS-1:0] COL_LEVEL_O,
	output logic HSYNC_OUT_O,
	output logic HSYNC_OE_O
);
	if (COLS < 1 || SCAN_DIV < 1 || SCAN_DIV > 65535 || DRIVE_CLKS < 1 || DRIVE_CLKS > 64 ||
		HSYNC_CLKS < 1 || HSYNC_CLKS > 64) begin
		$error("oled_drive_output_control: parameter out of range");
	end

	typedef struct packed {
		logic [4:0] dim_applied;
		logic [4:0] dim_pending;
		logic dim_wait;
		logic [1:0] row_mode;
		logic row_dir;
		logic dual;
		logic [3:0] ovr;
		logic [5:0] p1_count;
		logic [1:0] p1_level;
		logic disp_on;
		logic [2:0] vs_sync;
		logic vs_level;
		logic [15:0] div;
		oled_drive_pkg::phase_t phase;
		logic [5:0] pcnt;
		logic [6:0] row;
		logic hs_out;
		logic hs_oe;
		logic [2*COLS-1:0] col;
		logic waitreq;
		logic [31:0] rdata;
	} state_t;

	state_t st_q;
	state_t st_d;
	logic sclk_en;
	logic vs_rise;
	logic accept_wr;
	logic cmd_wr;
	logic [7:0] cmd_code;
	logic [7:0] cmd_data;
	logic last_clk;
	logic [6:0] lines;

	localparam logic [5:0] DRIVE_LAST = 6'(DRIVE_CLKS - 1);
	localparam logic [5:0] HSYNC_LAST = 6'(HSYNC_CLKS - 1);
	localparam logic [15:0] DIV_LAST = 16'(SCAN_DIV - 1);

	// Column drive level for one column in the current phase
	function automatic logic [1:0] col_level(input logic [3:0] ovr,
		input oled_drive_pkg::phase_t ph, input logic gray_zero, input logic pwm,
		input logic [1:0] p1_level);
		logic [1:0] lvl;
		lvl = oled_drive_pkg::LVL_GROUND;
		if (ovr[oled_drive_pkg::ALL_FLOAT_BIT] && ph != oled_drive_pkg::PH_HSYNC) begin
			lvl = oled_drive_pkg::LVL_FLOAT;
		end else if (ovr[oled_drive_pkg::ALL_FLOAT_BIT]) begin
			lvl = oled_drive_pkg::LVL_GROUND;
		end else if (ovr[oled_drive_pkg::ALL_SUPPLY_BIT]) begin
			lvl = oled_drive_pkg::LVL_SUPPLY;
		end else if (ph == oled_drive_pkg::PH_SETUP1) begin
			lvl = gray_zero ? oled_drive_pkg::LVL_GROUND : p1_level;
		end else if (ph == oled_drive_pkg::PH_DRIVE) begin
			if (pwm) begin
				lvl = oled_drive_pkg::LVL_CURRENT;
			end else if (ovr[oled_drive_pkg::POST_PWM_FLOAT_BIT]) begin
				lvl = oled_drive_pkg::LVL_FLOAT;
			end else begin
				lvl = oled_drive_pkg::LVL_GROUND;
			end
		end
		return lvl;
	endfunction

	always_comb begin
		lines = (st_q.row_mode == oled_drive_pkg::ROW_MODE_DUAL) ?
			oled_drive_pkg::LINES_DUAL : oled_drive_pkg::LINES_SINGLE;
		sclk_en = (st_q.div == DIV_LAST);
		vs_rise = (st_q.vs_sync[1] == st_q.vs_sync[2]) && st_q.vs_sync[2] && !st_q.vs_level;
		accept_wr = WRITE_I && !st_q.waitreq;
		cmd_code = WRITEDATA_I[15:8];
		cmd_data = WRITEDATA_I[7:0];
		cmd_wr = accept_wr && (ADDRESS_I == oled_drive_pkg::ADDR_CMD);
		unique case (st_q.phase)
			// A shorter count written mid-period ends the period at once instead of wrapping
			oled_drive_pkg::PH_SETUP1: last_clk = (st_q.pcnt >= st_q.p1_count);
			oled_drive_pkg::PH_DRIVE: last_clk = (st_q.pcnt == DRIVE_LAST);
			oled_drive_pkg::PH_HSYNC: last_clk = (st_q.pcnt == HSYNC_LAST);
			default: last_clk = 1'b1;
		endcase

		st_d = st_q;
		// Vertical sync pin: three stages, level moves once stages two and three agree
		st_d.vs_sync = {st_q.vs_sync[1:0], VSYNC_I};
		if (st_q.vs_sync[1] == st_q.vs_sync[2]) begin
			st_d.vs_level = st_q.vs_sync[2];
		end
		st_d.div = sclk_en ? 16'h0000 : st_q.div + 16'h0001;

		// Dimmer latch-up on vertical sync; a write in the same cycle wins
		if (vs_rise && st_q.dim_wait) begin
			st_d.dim_applied = st_q.dim_pending;
			st_d.dim_wait = 1'b0;
		end
		if (accept_wr && ADDRESS_I == oled_drive_pkg::ADDR_DISPLAY) begin
			st_d.disp_on = WRITEDATA_I[0];
		end
		if (cmd_wr) begin
			unique case (cmd_code)
				oled_drive_pkg::CMD_DIMMER: begin
					st_d.dim_pending = cmd_data[4:0];
					if (st_q.disp_on) begin
						st_d.dim_wait = 1'b1;
					end else begin
						st_d.dim_applied = cmd_data[4:0];
						st_d.dim_wait = 1'b0;
					end
				end
				oled_drive_pkg::CMD_ROW_SELECT: begin
					st_d.row_mode = cmd_data[1:0];
					st_d.row_dir = cmd_data[oled_drive_pkg::ROW_DIR_BIT];
				end
				oled_drive_pkg::CMD_COL_OVERRIDE: st_d.ovr = cmd_data[3:0];
				oled_drive_pkg::CMD_PHASE1: begin
					st_d.p1_count = cmd_data[5:0];
					st_d.p1_level = cmd_data[7:oled_drive_pkg::PHASE1_LEVEL_LSB];
				end
				default: ;
			endcase
		end
		st_d.dual = (st_d.row_mode == oled_drive_pkg::ROW_MODE_DUAL);

		// Line sequencer in scan clocks: setup period 1, drive, horizontal sync
		if (sclk_en) begin
			st_d.pcnt = last_clk ? 6'h00 : st_q.pcnt + 6'h01;
			if (last_clk) begin
				unique case (st_q.phase)
					oled_drive_pkg::PH_SETUP1: st_d.phase = oled_drive_pkg::PH_DRIVE;
					oled_drive_pkg::PH_DRIVE: st_d.phase = oled_drive_pkg::PH_HSYNC;
					oled_drive_pkg::PH_HSYNC: begin
						st_d.phase = oled_drive_pkg::PH_SETUP1;
						if (st_q.row >= lines) begin
							st_d.row = st_q.row_dir ? lines - 7'h01 : 7'h00;
						end else if (!st_q.row_dir) begin
							st_d.row = (st_q.row == lines - 7'h01) ? 7'h00 : st_q.row + 7'h01;
						end else begin
							st_d.row = (st_q.row == 7'h00) ? lines - 7'h01 : st_q.row - 7'h01;
						end
					end
					default: st_d.phase = oled_drive_pkg::PH_SETUP1;
				endcase
			end
		end

		// Horizontal sync output: idles high, low or released during the pulse
		st_d.hs_out = (st_q.phase != oled_drive_pkg::PH_HSYNC);
		st_d.hs_oe = !(st_q.phase == oled_drive_pkg::PH_HSYNC &&
			st_q.ovr[oled_drive_pkg::HSYNC_FLOAT_BIT] &&
			!st_q.ovr[oled_drive_pkg::ALL_FLOAT_BIT] &&
			!st_q.ovr[oled_drive_pkg::ALL_SUPPLY_BIT]);

		for (int i = 0; i < COLS; i++) begin
			st_d.col[2*i +: 2] = col_level(st_q.ovr, st_q.phase, GRAY_ZERO_I[i],
				PWM_ACTIVE_I[i], st_q.p1_level);
		end

		// Bus: every request is answered one cycle after it is first seen
		st_d.waitreq = 1'b1;
		if ((READ_I || WRITE_I) && st_q.waitreq) begin
			st_d.waitreq = 1'b0;
		end
		st_d.rdata = 32'h0000_0000;
		if (READ_I && st_q.waitreq) begin
			unique case (ADDRESS_I)
				oled_drive_pkg::ADDR_DISPLAY: st_d.rdata = {31'h0000_0000, st_q.disp_on};
				oled_drive_pkg::ADDR_STATUS: begin
					st_d.rdata[4:0] = st_q.dim_applied;
					st_d.rdata[oled_drive_pkg::STATUS_PENDING_BIT] = st_q.dim_wait;
					st_d.rdata[oled_drive_pkg::STATUS_ROW_LSB +: 7] = st_q.row;
					st_d.rdata[oled_drive_pkg::STATUS_PHASE_LSB +: 2] = st_q.phase;
				end
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_q <= '0;
			st_q.dim_applied <= oled_drive_pkg::DIMMER_RST;
			st_q.dim_pending <= oled_drive_pkg::DIMMER_RST;
			st_q.row_mode <= oled_drive_pkg::ROW_MODE_RST;
			st_q.row_dir <= oled_drive_pkg::ROW_DIR_RST;
			st_q.ovr <= oled_drive_pkg::OVERRIDE_RST;
			st_q.p1_count <= oled_drive_pkg::PHASE1_COUNT_RST;
			st_q.p1_level <= oled_drive_pkg::PHASE1_LEVEL_RST;
			st_q.phase <= oled_drive_pkg::PH_SETUP1;
			st_q.hs_out <= 1'b1;
			st_q.hs_oe <= 1'b1;
			st_q.waitreq <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign CURRENT_FRACTION_CODE_O = st_q.dim_applied;
	assign ROW_O = st_q.row;
	assign DUAL_SCAN_O = st_q.dual;
	assign COL_LEVEL_O = st_q.col;
	assign HSYNC_OUT_O = st_q.hs_out;
	assign HSYNC_OE_O = st_q.hs_oe;
	assign READDATA_O = st_q.rdata;
	assign WAITREQUEST_O = st_q.waitreq;

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);

	logic wr_dim;
	logic wr_other;
	logic advance;
	assign wr_dim = cmd_wr && cmd_code == oled_drive_pkg::CMD_DIMMER;
	assign wr_other = cmd_wr && cmd_code != oled_drive_pkg::CMD_PHASE1;
	assign advance = sclk_en && last_clk && st_q.phase == oled_drive_pkg::PH_HSYNC;

	sequence s_dim_held;
		wr_dim && st_q.disp_on && !vs_rise;
	endsequence
	property p_dim_immediate;
		wr_dim && !st_q.disp_on |=> st_q.dim_applied == $past(WRITEDATA_I[4:0]);
	endproperty
	a_dim_immediate: assert property (p_dim_immediate) else $error("dimmer not applied");
	property p_dim_waits;
		s_dim_held |=> st_q.dim_applied == $past(st_q.dim_applied) && st_q.dim_wait;
	endproperty
	a_dim_waits: assert property (p_dim_waits) else $error("dimmer applied early");
	property p_dim_on_vsync;
		vs_rise && st_q.dim_wait && !wr_dim |=> st_q.dim_applied == $past(st_q.dim_pending);
	endproperty
	a_dim_on_vsync: assert property (p_dim_on_vsync) else $error("dimmer missed vsync");
	property p_dual_wrap;
		advance && DUAL_SCAN_O && !st_q.row_dir && st_q.row == 7'h23 |=> st_q.row == 7'h00;
	endproperty
	a_dual_wrap: assert property (p_dual_wrap) else $error("dual scan did not wrap");
	property p_reverse;
		advance && st_q.row_dir && st_q.row > 7'h00 && st_q.row < lines
			|=> st_q.row == $past(st_q.row) - 7'h01;
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse scan wrong");
	property p_setup_len;
		st_q.phase == oled_drive_pkg::PH_SETUP1 && sclk_en
			|=> st_q.phase == (st_q.pcnt == 6'h00 && $past(st_q.pcnt) >= $past(st_q.p1_count) ?
			oled_drive_pkg::PH_DRIVE : oled_drive_pkg::PH_SETUP1);
	endproperty
	a_setup_len: assert property (p_setup_len) else $error("setup period length wrong");
	property p_all_float;
		st_q.ovr[oled_drive_pkg::ALL_FLOAT_BIT] && st_q.phase != oled_drive_pkg::PH_HSYNC
			|=> COL_LEVEL_O == {COLS{oled_drive_pkg::LVL_FLOAT}};
	endproperty
	a_all_float: assert property (p_all_float) else $error("columns not floating");
	property p_all_supply;
		st_q.ovr[oled_drive_pkg::ALL_SUPPLY_BIT] && !st_q.ovr[oled_drive_pkg::ALL_FLOAT_BIT]
			|=> COL_LEVEL_O == {COLS{oled_drive_pkg::LVL_SUPPLY}};
	endproperty
	a_all_supply: assert property (p_all_supply) else $error("columns not at supply");
	property p_zero_gray;
		st_q.phase == oled_drive_pkg::PH_SETUP1 && st_q.ovr == 4'h0 && GRAY_ZERO_I[0]
			|=> COL_LEVEL_O[1:0] == oled_drive_pkg::LVL_GROUND;
	endproperty
	a_zero_gray: assert property (p_zero_gray) else $error("zero gray not grounded");
	property p_hsync_float;
		st_q.phase == oled_drive_pkg::PH_HSYNC && st_q.ovr == 4'h2 |=> !HSYNC_OE_O;
	endproperty
	a_hsync_float: assert property (p_hsync_float) else $error("hsync not released");
	property p_cmd_only_named;
		wr_other |=> st_q.p1_count == $past(st_q.p1_count);
	endproperty
	a_cmd_only_named: assert property (p_cmd_only_named) else $error("wrong register hit");
endmodule
`default_nettype wire

// ===== verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock
	input wire logic clk_i,
	// Avalon-MM master
	output logic [3:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [31:0] writedata_o,
	input wire logic [31:0] readdata_i,
	input wire logic waitrequest_i
);
	initial begin
		address_o = 4'h0;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h00000000;
	end
	task automatic access(input logic rd, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		address_o <= a;
		read_o <= rd;
		write_o <= !rd;
		writedata_o <= d;
		do @(posedge clk_i); while (waitrequest_i !== 1'b0);
		q = readdata_i;
		read_o <= 1'b0;
		write_o <= 1'b0;
		// Released lines do not keep their last value
		address_o <= ~a;
		writedata_o <= ~d;
	endtask
	task automatic cmd(input logic [7:0] code, input logic [7:0] data);
		logic [31:0] q;
		logic [7:0] v;
		v = data;
		// Reserved row modes are never sent
		if (code == oled_drive_pkg::CMD_ROW_SELECT) v[1] = 1'b1;
		access(1'b0, oled_drive_pkg::ADDR_CMD, {16'h0000, code, v}, q);
	endtask
endmodule
`default_nettype wire

// ===== verif/oled_drive_output_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module oled_drive_output_control_test;
	localparam int D = 2;
	localparam int DR = 4;
	localparam int HS = 2;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic vsync = 1'b0;
	logic [3:0] addr;
	logic rd;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic wait_req;
	logic [4:0] frac;
	logic [6:0] row;
	logic dual;
	logic [7:0] lvl;
	logic hs_out;
	logic hs_oe;
	logic [3:0] gz = 4'h0;
	logic [3:0] pwm = 4'h0;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	int hist[4][4];
	int hs_low;
	int hs_z;
	logic [31:0] seed = 32'h0000912B;
	always #5 clk = ~clk;
	host_model u_host (.clk_i(clk), .address_o(addr), .read_o(rd), .write_o(wr),
		.writedata_o(wdata), .readdata_i(rdata), .waitrequest_i(wait_req));
	oled_drive_output_control #(.COLS(4), .SCAN_DIV(D), .DRIVE_CLKS(DR), .HSYNC_CLKS(HS)) u_dut (
		.CLOCK_I(clk), .NRST_I(nrst), .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr),
		.WRITEDATA_I(wdata), .READDATA_O(rdata), .WAITREQUEST_O(wait_req), .VSYNC_I(vsync),
		.GRAY_ZERO_I(gz), .PWM_ACTIVE_I(pwm), .CURRENT_FRACTION_CODE_O(frac), .ROW_O(row),
		.DUAL_SCAN_O(dual), .COL_LEVEL_O(lvl), .HSYNC_OUT_O(hs_out), .HSYNC_OE_O(hs_oe));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Cycles per two lines that a column spends at level v
	function automatic int exp_cnt(logic gz, logic pwm, logic [3:0] ov, logic [1:0] l, int c,
		logic [1:0] v);
		logic [1:0] s;
		logic [1:0] dv;
		logic [1:0] h;
		s = ov[2] ? 2'h1 : ov[3] ? 2'h2 : gz ? 2'h0 : l;
		dv = ov[2] ? 2'h1 : ov[3] ? 2'h2 : pwm ? 2'h3 : {1'b0, ov[0]};
		h = (ov[3] && !ov[2]) ? 2'h2 : 2'h0;
		return 2 * D * (int'(s == v) * (c + 1) + int'(dv == v) * DR + int'(h == v) * HS);
	endfunction
	task automatic end_sim();
		$display("Counts: %0d checks, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			end_sim();
		end
	end
	task automatic measure(int n);
		for (int i = 0; i < 4; i++) for (int k = 0; k < 4; k++) hist[i][k] = 0;
		hs_low = 0;
		hs_z = 0;
		repeat (n) begin
			@(negedge clk);
			for (int i = 0; i < 4; i++) hist[i][lvl[2*i +: 2]]++;
			if (hs_oe === 1'b0) hs_z++;
			if (hs_oe === 1'b1 && hs_out === 1'b0) hs_low++;
		end
	endtask
	task automatic level_case(logic [3:0] ov, logic [1:0] l, logic [5:0] c, logic [3:0] g,
		logic [3:0] p);
		int line;
		line = (c + 1 + DR + HS) * D;
		@(posedge clk);
		gz <= g;
		pwm <= p;
		u_host.cmd(oled_drive_pkg::CMD_COL_OVERRIDE, {4'h0, ov});
		u_host.cmd(oled_drive_pkg::CMD_PHASE1, {l, c});
		// Let the line in progress finish, plus one scan clock for the output lag
		repeat (line + D) @(posedge clk);
		measure(2 * line);
		for (int v = 0; v < 4; v++) begin
			`CHK(hist[0][v], exp_cnt(g[0], p[0], ov, l, c, 2'(v)), "col0 time")
			`CHK(hist[2][v], exp_cnt(g[2], p[2], ov, l, c, 2'(v)), "col2 time")
			if (ov[3:2] == 2'h0) `CHK(hist[1][v], exp_cnt(g[1], p[1], ov, l, c, 2'(v)), "col1 time")
			`CHK(hist[3][v], exp_cnt(g[3], p[3], ov, l, c, 2'(v)), "col3 time")
		end
		`CHK(hs_z, (ov[1] && ov[3:2] == 2'h0) ? 2 * HS * D : 0, "hsync float")
		`CHK(hs_low, (ov[1] && ov[3:2] == 2'h0) ? 0 : 2 * HS * D, "hsync low")
		$display("Level test done ov=%h l=%h c=%0d", ov, l, c);
	endtask
	task automatic row_case(logic [1:0] m, logic dir, int n, int lines);
		logic [6:0] prev;
		int bad;
		int mx;
		u_host.cmd(oled_drive_pkg::CMD_ROW_SELECT, {3'h0, dir, 2'h0, m});
		repeat (30) @(posedge clk);
		@(negedge clk);
		prev = row;
		bad = 0;
		mx = 0;
		repeat (n) begin
			@(negedge clk);
			if (row !== prev && row !== 7'(dir ? (prev == 0 ? lines - 1 : prev - 1)
				: (prev == lines - 1 ? 0 : prev + 1))) bad++;
			if (int'(row) > mx) mx = row;
			prev = row;
		end
		`CHK(bad, 0, "row step")
		`CHK(mx, lines - 1, "row span")
		`CHK(dual, m[0], "dual flag")
		$display("Row test done mode=%h dir=%b", m, dir);
	endtask
	initial begin
		logic [31:0] q;
		logic [31:0] r;
		logic [4:0] code;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		`CHK(frac, oled_drive_pkg::DIMMER_RST, "dimmer reset")
		`CHK(dual, 1'b0, "mode reset")
		`CHK(row, 7'h00, "row reset")
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			code = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : r[4:0];
			u_host.cmd(oled_drive_pkg::CMD_DIMMER, {3'h0, code});
			@(posedge clk);
			@(negedge clk);
			`CHK(frac, code, "dimmer at once")
			u_host.cmd(8'h15, r[15:8]);
			@(posedge clk);
			@(negedge clk);
			`CHK(frac, code, "foreign code")
		end
		$display("Dimmer test done");
		u_host.access(1'b0, oled_drive_pkg::ADDR_DISPLAY, 32'h00000001, q);
		u_host.cmd(oled_drive_pkg::CMD_DIMMER, {3'h0, ~code});
		repeat (10) @(negedge clk);
		`CHK(frac, code, "dimmer held")
		u_host.access(1'b1, oled_drive_pkg::ADDR_STATUS, 32'h00000000, q);
		`CHK(q[oled_drive_pkg::STATUS_PENDING_BIT], 1'b1, "pending")
		@(posedge clk);
		vsync <= 1'b1;
		repeat (8) @(negedge clk);
		`CHK(frac, ~code, "dimmer on vsync")
		@(posedge clk);
		vsync <= 1'b0;
		u_host.access(1'b0, oled_drive_pkg::ADDR_DISPLAY, 32'h00000000, q);
		u_host.access(1'b1, 4'hC, 32'h00000000, q);
		`CHK(q, 32'h00000000, "unmapped read")
		$display("Vsync test done");
		level_case(4'h0, 2'h3, 6'h00, 4'h3, 4'h5);
		level_case(4'h0, 2'h1, 6'h3F, 4'hC, 4'hA);
		for (int ov = 0; ov < 16; ov++) begin
			r = rnd();
			level_case(4'(ov), r[7:6], r[5:0], r[11:8], r[15:12]);
		end
		u_host.cmd(oled_drive_pkg::CMD_PHASE1, 8'h00);
		row_case(2'h2, 1'b0, 1100, 72);
		row_case(2'h2, 1'b1, 1100, 72);
		row_case(2'h3, 1'b0, 600, 36);
		row_case(2'h3, 1'b1, 600, 36);
		end_sim();
	end
endmodule
`default_nettype wire
